// File: design/rcsc_defs.vh
/*
  constants for the reset cause status and control block: register
  offsets, bit positions, reset values.
  assumes inclusion by its bare name from design files.
*/
`ifndef RCSC_DEFS_VH
`define RCSC_DEFS_VH

`define RCSC_OFF_CAUSE      4'h0
`define RCSC_OFF_STATUS     4'h4
`define RCSC_OFF_MASK       4'h8
`define RCSC_OFF_CTRL       4'hc

`define RCSC_BIT_TRAP       15
`define RCSC_BIT_ILLOP      14
`define RCSC_BIT_VREG       8
`define RCSC_BIT_PIN        7
`define RCSC_BIT_INSTR      6
`define RCSC_BIT_SWDOG      5
`define RCSC_BIT_DOGTO      4
`define RCSC_BIT_SLEEP      3
`define RCSC_BIT_IDLE       2
`define RCSC_BIT_BROWN      1
`define RCSC_BIT_POR        0

`define RCSC_IMPL_MASK      16'hc1ff
`define RCSC_CAUSE_RST      16'h0003
`define RCSC_FLAG_MASK      16'hc0df
`define RCSC_EV_W           9
`define RCSC_RESP_OKAY      2'b00
`define RCSC_RESP_SLVERR    2'b10

`endif

// File: design/rcsc_edge.v
/*
  rising edge detector: one-cycle pulse per rising edge of each bit.
  assumes synchronised inputs on aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rcsc_edge #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] lvl,
  output wire [W-1:0] rise
);
  reg [W-1:0] prev_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
      prev_q <= {W{1'b0}};
    else
      prev_q <= lvl;
  end
  assign rise = lvl & ~prev_q;
endmodule // rcsc_edge
`default_nettype wire

// File: design/rcsc_sync.v
/*
  two flip-flop synchroniser for a vector of level inputs.
  assumes inputs come from outside the aclk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module rcsc_sync #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // rcsc_sync
`default_nettype wire

// File: design/rcsc_top.v
/*
  reset cause status and control register block with an axi4-lite slave,
  sticky event status with mask and one level interrupt.
  assumes event inputs are levels from other reset/power logic, possibly
  asynchronous; aresetn is the power-on reset of this block only, other
  reset kinds are reported as events and do not reset the flags.
*/
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "rcsc_defs.vh"
// Functional notes
// - trap conflict reset sets bit 15, otherwise it holds.
// - illegal opcode, address mode or pointer reset sets bit 14.
// - bit 8 one keeps regulator active in sleep, zero lets it stand by.
// - master clear pin reset sets bit 7.
// - reset instruction sets bit 6; zero until one has run.
// - bit 5 written one enables watchdog, zero disables it.
// - fuse bit at one keeps watchdog enabled regardless of bit 5.
// - having been in sleep sets bit 3.
// - having been in idle sets bit 2.
// - brown-out reset sets bit 1.
// - after power-on bits 1 and 0 read one, others zero.
// - software may set or clear flags; writes never cause a reset.
// - bits 13 to 9 read zero and ignore writes.
module rcsc_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        trap_conflict_evt,
  input  wire        illegal_op_evt,
  input  wire        pin_reset_evt,
  input  wire        instr_reset_evt,
  input  wire        dog_timeout_evt,
  input  wire        sleep_evt,
  input  wire        idle_evt,
  input  wire        brownout_evt,
  input  wire        dog_fuse_enable,
  output reg         dog_enable,
  output reg         regulator_sleep_active,
  output reg         irq
);

  // event order: 8 brown,7 trap,6 illop,5 pin,4 instr,3 dogto,2 sleep,1 idle,0 unused
  wire [`RCSC_EV_W-1:0] ev_raw;
  wire [`RCSC_EV_W-1:0] ev_lvl;
  wire [`RCSC_EV_W-1:0] ev_rise;
  wire                  fuse_s;

  // positions of the events in the synchronised vector
  localparam EV_IDLE  = 1;
  localparam EV_SLEEP = 2;
  localparam EV_DOGTO = 3;
  localparam EV_INSTR = 4;
  localparam EV_PIN   = 5;
  localparam EV_ILLOP = 6;
  localparam EV_TRAP  = 7;
  localparam EV_BROWN = 8;

  assign ev_raw = {brownout_evt, trap_conflict_evt, illegal_op_evt, pin_reset_evt,
                   instr_reset_evt, dog_timeout_evt, sleep_evt, idle_evt, 1'b0};

  rcsc_sync #(.W(`RCSC_EV_W)) u_sync_ev (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (ev_raw),
    .q       (ev_lvl)
  );

  rcsc_sync #(.W(1)) u_sync_fuse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (dog_fuse_enable),
    .q       (fuse_s)
  );

  rcsc_edge #(.W(`RCSC_EV_W)) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lvl     (ev_lvl),
    .rise    (ev_rise)
  );

  // hardware set vector laid out like the cause register
  reg [15:0] hw_set;
  always @*
  begin
    hw_set = 16'h0000;
    hw_set[`RCSC_BIT_TRAP]  = ev_rise[EV_TRAP];
    hw_set[`RCSC_BIT_ILLOP] = ev_rise[EV_ILLOP];
    hw_set[`RCSC_BIT_PIN]   = ev_rise[EV_PIN];
    hw_set[`RCSC_BIT_INSTR] = ev_rise[EV_INSTR];
    hw_set[`RCSC_BIT_DOGTO] = ev_rise[EV_DOGTO];
    hw_set[`RCSC_BIT_SLEEP] = ev_rise[EV_SLEEP];
    hw_set[`RCSC_BIT_IDLE]  = ev_rise[EV_IDLE];
    hw_set[`RCSC_BIT_BROWN] = ev_rise[EV_BROWN];
  end

  // ---- axi4-lite write channel ----
  reg        aw_hold_q;
  reg [3:0]  aw_addr_q;
  reg        w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       wr_fire;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // only the three mapped word offsets answer okay
  wire wr_err;
  assign wr_err = !(aw_addr_q == `RCSC_OFF_CAUSE || aw_addr_q == `RCSC_OFF_STATUS ||
                    aw_addr_q == `RCSC_OFF_MASK);

  // address half: held until the write completes, then free again
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      aw_addr_q     <= 4'h0;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awready && s_axi_awvalid);
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (wr_fire)
        aw_hold_q <= 1'b0;
    end
  end

  // data half: held until the write completes, then free again
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_hold_q && !(s_axi_wready && s_axi_wvalid);
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
        w_hold_q <= 1'b0;
    end
  end

  // response: raised once both halves are held, kept until taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RCSC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `RCSC_RESP_SLVERR : `RCSC_RESP_OKAY;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // byte-lane mask of the held write
  wire [15:0] lane_mask;
  assign lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  wire wr_cause;
  wire wr_mask;
  assign wr_cause = wr_fire && (aw_addr_q == `RCSC_OFF_CAUSE);
  assign wr_mask  = wr_fire && (aw_addr_q == `RCSC_OFF_MASK);

  // ---- read channel ----
  wire rd_fire;
  wire rd_status;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign rd_status = rd_fire && (s_axi_araddr == `RCSC_OFF_STATUS);

  // ---- reset cause register ----
  reg [15:0] cause_q;
  reg [15:0] cause_d;
  reg [15:0] status_q;
  reg [15:0] status_d;
  reg [15:0] mask_q;
  reg [15:0] mask_d;

  always @*
  begin
    cause_d = cause_q;
    if (wr_cause)
      cause_d = (cause_q & ~lane_mask) | (w_data_q[15:0] & lane_mask);
    // hardware set wins over software clear
    cause_d = cause_d | hw_set;
    cause_d = cause_d & `RCSC_IMPL_MASK;
  end

  always @*
  begin
    status_d = status_q;
    if (rd_status)
      status_d = 16'h0000;
    status_d = (status_d | hw_set) & `RCSC_FLAG_MASK;
  end

  // mask keeps only the flag positions
  always @*
  begin
    mask_d = mask_q;
    if (wr_mask)
      mask_d = ((mask_q & ~lane_mask) | (w_data_q[15:0] & lane_mask)) & `RCSC_FLAG_MASK;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      cause_q <= `RCSC_CAUSE_RST;
    else
      cause_q <= cause_d;
  end

  // event status starts like the cause flags after power-on
  always @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= `RCSC_CAUSE_RST;
    else
      status_q <= status_d;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= 16'h0000;
    else
      mask_q <= mask_d;
  end

  // ---- read data path ----
  reg [15:0] rd_mux;
  reg        rd_err;
  always @*
  begin
    rd_mux = 16'h0000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `RCSC_OFF_CAUSE:  rd_mux = cause_q;
      `RCSC_OFF_STATUS: rd_mux = status_q;
      `RCSC_OFF_MASK:   rd_mux = mask_q;
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RCSC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_mux};
        s_axi_rresp  <= rd_err ? `RCSC_RESP_SLVERR : `RCSC_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---- control outputs ----
  // software dog enable; fuse override
  always @(posedge aclk)
  begin
    if (!aresetn)
      dog_enable <= 1'b0;
    else
      dog_enable <= cause_d[`RCSC_BIT_SWDOG] | fuse_s;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      regulator_sleep_active <= 1'b0;
    else
      regulator_sleep_active <= cause_d[`RCSC_BIT_VREG];
  end

  // level interrupt from the flags as they will stand
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_d & mask_q);
  end

endmodule // rcsc_top
`default_nettype wire

// File: sim/rcsc_properties.sv
/*
  checker for the rcsc_top axi4-lite slave and its control outputs.
  assumes a bind to rcsc_top and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module rcsc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        dog_fuse_enable,
  input wire logic        dog_enable,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_rd_gap: assert property (s_axi_rvalid |-> s_axi_rdata[13:9] == 5'h0)
    else $error("unimplemented cause bits not zero");
  a_ar_held: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_fuse_force: assert property (dog_fuse_enable [*4] |=> dog_enable)
    else $error("fuse does not force watchdog");
  a_reset_quiet: assert property ($rose(aresetn) |->
    !irq && !s_axi_bvalid && !s_axi_rvalid && !dog_enable)
    else $error("outputs active after reset");
endmodule // rcsc_props
bind rcsc_top rcsc_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .dog_fuse_enable, .dog_enable,
  .irq);
`default_nettype wire

// File: sim/tb_reset_cause_status_control.sv
/*
  bench for rcsc_top: axi4-lite tasks, register and event tests.
  assumes rcsc_defs.vh offsets and a 25 mhz aclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rcsc_defs.vh"
module tb_reset_cause_status_control;
  logic        aclk = 0, aresetn = 0, dog_fuse_enable = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        dog_enable, regulator_sleep_active, irq;
  logic [7:0]  ev = 0;
  int          fail_count = 0, n_tests = 0, cyc = 0, i;
  int          pos [8] = '{1, 2, 3, 4, 6, 7, 14, 15};
  always #20 aclk = ~aclk;
  rcsc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trap_conflict_evt(ev[7]), .illegal_op_evt(ev[6]), .pin_reset_evt(ev[5]),
    .instr_reset_evt(ev[4]), .dog_timeout_evt(ev[3]), .sleep_evt(ev[2]), .idle_evt(ev[1]),
    .brownout_evt(ev[0]), .dog_fuse_enable, .dog_enable, .regulator_sleep_active, .irq);
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // response ready goes up with the request and drops once the answer is seen
  task wr(input [3:0] a, input [15:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rdr(input [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task rchk(input string s, input [3:0] a, input [31:0] e);
    rdr(a);
    chk(s, e, rd);
  endtask
  task pulse(input int k);
    @(posedge aclk);
    ev[k] <= 1;
    repeat (2) @(posedge aclk);
    ev[k] <= 0;
    repeat (5) @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rchk("cause", `RCSC_OFF_CAUSE, 32'h3);
    rchk("status", `RCSC_OFF_STATUS, 32'h3);
    rchk("mask", `RCSC_OFF_MASK, 32'h0);
    chk("irq", 0, irq);
    $display("end reset test");
    rchk("unmapped", `RCSC_OFF_CTRL, 32'h0);
    chk("rresp", `RCSC_RESP_SLVERR, rr);
    wr(`RCSC_OFF_CTRL, 16'hffff);
    chk("bresp", `RCSC_RESP_SLVERR, rr);
    wr(`RCSC_OFF_CAUSE, 16'hffff);
    chk("bresp", `RCSC_RESP_OKAY, rr);
    rchk("cause", `RCSC_OFF_CAUSE, 32'hc1ff);
    rchk("status", `RCSC_OFF_STATUS, 32'h0);
    chk("regulator", 1, regulator_sleep_active);
    chk("dog", 1, dog_enable);
    wr(`RCSC_OFF_CAUSE, 16'h0);
    rchk("cause", `RCSC_OFF_CAUSE, 32'h0);
    chk("regulator", 0, regulator_sleep_active);
    chk("dog", 0, dog_enable);
    s_axi_wstrb <= 4'h1;
    wr(`RCSC_OFF_CAUSE, 16'hffff);
    rchk("cause", `RCSC_OFF_CAUSE, 32'hff);
    chk("regulator", 0, regulator_sleep_active);
    s_axi_wstrb <= 4'hf;
    wr(`RCSC_OFF_CAUSE, 16'h0);
    dog_fuse_enable <= 1;
    repeat (5) @(posedge aclk);
    chk("dog", 1, dog_enable);
    dog_fuse_enable <= 0;
    repeat (4) @(posedge aclk);
    chk("dog", 0, dog_enable);
    $display("end control test");
    for (i = 0; i < 8; i++)
    begin
      pulse(i);
      rchk("cause", `RCSC_OFF_CAUSE, 32'h1 << pos[i]);
      wr(`RCSC_OFF_CAUSE, 16'h0);
    end
    rchk("status", `RCSC_OFF_STATUS, 32'hc0de);
    $display("end event test");
    wr(`RCSC_OFF_MASK, 16'h8000);
    pulse(5);
    chk("irq", 0, irq);
    pulse(7);
    chk("irq", 1, irq);
    rchk("cause", `RCSC_OFF_CAUSE, 32'h8080);
    rchk("status", `RCSC_OFF_STATUS, 32'h8080);
    repeat (3) @(posedge aclk);
    chk("irq", 0, irq);
    $display("end interrupt test");
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rchk("cause", `RCSC_OFF_CAUSE, 32'h3);
    $display("end power-on test");
    complete_run;
  end
endmodule // tb_reset_cause_status_control
`default_nettype wire
